// File: rtl/eau_defines.vh
// Constants for the extended arithmetic unit: operation codes, timing
// and condition code bit positions. Definitions only.
`ifndef EAU_DEFINES_VH
`define EAU_DEFINES_VH

// Operation codes on op_sel
`define EAU_OP_MUL 2'h0
`define EAU_OP_DIV 2'h1
`define EAU_OP_ASH 2'h2
`define EAU_OP_COMBINED_ARITH_SHIFT_OP 2'h3

// Condition code bit positions in cc_out {n,z,v,c}
`define EAU_CC_N 3
`define EAU_CC_Z 2
`define EAU_CC_V 1
`define EAU_CC_C 0

// Clock period and time per shift position, in ns
`define EAU_CLK_NS 20
`define EAU_SHIFT_STEP_NS 300
// Cycles per shift position, least time so rounded up
`define EAU_SHIFT_STEP_CYC ((`EAU_SHIFT_STEP_NS + `EAU_CLK_NS - 1) / `EAU_CLK_NS)

// Base cycles before result for multiply and divide iterations
`define EAU_MUL_STEPS 16
`define EAU_DIV_STEPS 6'h20

`endif

// File: rtl/eau_mul.v
// Iterative signed 16x16 multiplier giving a 32-bit product.
// Assumes start is a one-cycle pulse and operands hold only at start.
`timescale 1ns/1ps
`include "eau_defines.vh"

module eau_mul (
   input wire sys_clk,
   input wire rst_n,
   input wire start,
   input wire [15:0] mcand,
   input wire [15:0] mplier,
   output reg done,
   output reg [31:0] product
);
   reg [31:0] acc;
   reg [31:0] addend;
   reg [15:0] bits;
   reg [4:0] cnt;
   reg busy;

   // Shift-and-add on the two's-complement operands, multiplicand sign-extended; top bit weighs -2^15
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= 32'h0;
         addend <= 32'h0;
         bits <= 16'h0;
         cnt <= 5'h0;
         busy <= 1'b0;
         done <= 1'b0;
         product <= 32'h0;
      end else begin
         done <= 1'b0;
         if (start) begin
            acc <= 32'h0;
            addend <= {{16{mcand[15]}}, mcand};
            bits <= mplier;
            cnt <= 5'h0;
            busy <= 1'b1;
         end else if (busy) begin
            if (bits[0]) begin
               // Sign weight of multiplier bit 15 subtracts
               if (cnt == 5'hF) begin
                  acc <= acc - addend; // RULE1
               end else begin
                  acc <= acc + addend; // RULE1
               end
            end
            addend <= {addend[30:0], 1'b0};
            bits <= {1'b0, bits[15:1]};
            cnt <= cnt + 5'h1;
            if (cnt == 5'hF) begin
               busy <= 1'b0;
               done <= 1'b1;
               product <= bits[0] ? (acc - addend) : acc;
            end
         end
      end
   end
endmodule

// File: rtl/eau_div.v
// Iterative signed 32/16 divider, restoring on magnitudes.
// Flags overflow for zero divisor or a quotient beyond 16 bits.
`timescale 1ns/1ps
`include "eau_defines.vh"

module eau_div (
   input wire sys_clk,
   input wire rst_n,
   input wire start,
   input wire [31:0] dividend,
   input wire [15:0] divisor,
   output reg done,
   output reg ovf,
   output reg [15:0] quot,
   output reg [15:0] rem
);
   reg [31:0] q_mag;
   reg [32:0] r_mag;
   reg [15:0] d_mag;
   reg neg_q;
   reg neg_r;
   reg [5:0] cnt;
   reg busy;
   reg [32:0] trial;
   reg [31:0] q_s;
   reg [15:0] r_s;
   reg q_bad;

   // Trial subtract and signed fix-up of the final step
   always @* begin
      trial = {r_mag[31:0], q_mag[31]} - {17'h0, d_mag};
      q_s = neg_q ? (32'h0 - q_mag) : q_mag;
      r_s = neg_r ? (16'h0 - r_mag[15:0]) : r_mag[15:0];
      // Quotient must survive as a signed 16-bit value
      q_bad = (q_s[31:15] != {17{q_s[15]}}); // RULE6
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q_mag <= 32'h0;
         r_mag <= 33'h0;
         d_mag <= 16'h0;
         neg_q <= 1'b0;
         neg_r <= 1'b0;
         cnt <= 6'h0;
         busy <= 1'b0;
         done <= 1'b0;
         ovf <= 1'b0;
         quot <= 16'h0;
         rem <= 16'h0;
      end else begin
         done <= 1'b0;
         if (start) begin
            q_mag <= dividend[31] ? (32'h0 - dividend) : dividend;
            d_mag <= divisor[15] ? (16'h0 - divisor) : divisor;
            r_mag <= 33'h0;
            neg_q <= dividend[31] ^ divisor[15];
            neg_r <= dividend[31]; // RULE5
            cnt <= 6'h0;
            if (divisor == 16'h0) begin
               // Zero divisor ends at once as overflow
               done <= 1'b1; // RULE8
               ovf <= 1'b1; // RULE8
            end else begin
               busy <= 1'b1;
               ovf <= 1'b0;
            end
         end else if (busy) begin
            if (!trial[32]) begin
               r_mag <= trial;
               q_mag <= {q_mag[30:0], 1'b1};
            end else begin
               r_mag <= {r_mag[31:0], q_mag[31]};
               q_mag <= {q_mag[30:0], 1'b0};
            end
            cnt <= cnt + 6'h1;
            if (cnt == `EAU_DIV_STEPS) begin
               busy <= 1'b0;
            end
         end
         // Final fix-up one cycle after the last step
         if (busy && cnt == `EAU_DIV_STEPS) begin
            done <= 1'b1;
            ovf <= q_bad; // RULE6
            quot <= q_s[15:0]; // RULE4
            rem <= r_s; // RULE4 RULE5
         end
      end
   end
endmodule

// File: rtl/eau_top.v
// Contract
// RULE1: Multiply signed 16x16 into 32-bit product
// RULE2: Even register gets high, next gets low
// RULE3: Odd register gets only the low half
// RULE4: Divide 32 by 16, quotient R, remainder R+1; code writes the remainder to R|1, so odd R gets the remainder
// RULE5: Nonzero remainder carries the dividend's sign
// RULE6: Quotient beyond 16 bits aborts, sets V
// RULE7: Overflow loads expansion status word and traps
// RULE8: Zero divisor treated as divide overflow
// RULE9: Shift count is signed low 6 bits
// RULE10: Positive left, negative right, +31 to -32
// RULE11: Zero count leaves operand unchanged
// RULE12: Combined shift joins R high, R+1 low
// RULE13: Odd register in combined shift rotates
// RULE14: Every instruction updates condition codes
// RULE15: Results go to general registers only
// RULE16: Never delays nonprocessor transfer service
// RULE17: Interrupts wait for instruction end
// RULE18: Shift adds 300 ns per count position
// RULE19: Right shift fills sign, left fills zero
//
// Extended arithmetic unit: multiply, divide, shift and combined shift.
// Assumes the processor core fetches operands, pulses start for one
// cycle and writes back the results that the done pulse presents.
`timescale 1ns/1ps
`include "eau_defines.vh"

module eau_top (
   input wire sys_clk,
   input wire rst_n,
   input wire start,
   input wire [1:0] op_sel,
   input wire [2:0] reg_num,
   input wire [15:0] src_operand,
   input wire [15:0] pair_low,
   input wire [15:0] dst_operand,
   input wire [15:0] expansion_status_word,
   input wire nonprocessor_transfer_request,
   input wire irq_pending,
   output reg busy,
   output reg done,
   output reg wr_en_a,
   output reg [2:0] wr_addr_a,
   output reg [15:0] wr_data_a,
   output reg wr_en_b,
   output reg [2:0] wr_addr_b,
   output reg [15:0] wr_data_b,
   output reg cc_wr,
   output reg [3:0] cc_out,
   output reg trap,
   output reg [15:0] processor_status_word,
   output reg psw_load,
   output reg irq_take,
   output reg bus_grant
);
   localparam ST_IDLE = 2'h0;
   localparam ST_MUL = 2'h1;
   localparam ST_DIV = 2'h2;
   localparam ST_SHIFT = 2'h3;
   localparam [31:0] STEP_FULL = `EAU_SHIFT_STEP_CYC;
   localparam [4:0] STEP_CYC = STEP_FULL[4:0];

   reg [1:0] state;
   reg [1:0] next_state;
   reg [2:0] r_num;
   reg [31:0] sh_val;
   reg sh_pair;
   reg sh_rot;
   reg sh_left;
   reg [5:0] sh_left_cnt;
   reg [4:0] step_cnt;
   reg sh_v;
   reg sh_c;
   reg mul_start;
   reg div_start;
   reg [15:0] mul_a;
   reg [15:0] mul_b;
   reg [31:0] div_n;
   reg [15:0] div_d;
   reg irq_s1;
   reg irq_s2;
   reg npr_s1;
   reg npr_s2;
   wire mul_done;
   wire [31:0] mul_prod;
   wire div_done;
   wire div_ovf;
   wire [15:0] div_q;
   wire [15:0] div_r;
   wire [5:0] cnt6;
   wire [5:0] cnt_mag;
   wire [31:0] sh_next;
   wire [31:0] dividend;

   // Signed count from low six bits of destination
   // Count -32 gives magnitude 32, which still fits six bits
   assign cnt6 = dst_operand[5:0]; // RULE9
   assign cnt_mag = cnt6[5] ? (6'h0 - cnt6) : cnt6; // RULE10
   assign dividend = {src_operand, pair_low}; // RULE4

   // One position per step; right fills sign, left fills zero, rotate wraps
   assign sh_next = sh_rot ? (sh_left ? {16'h0, sh_val[14:0], sh_val[15]}
                                      : {16'h0, sh_val[0], sh_val[15:1]}) // RULE13
                  : sh_left ? {sh_val[30:0], 1'b0} // RULE19
                  : {sh_val[31], sh_val[31:1]}; // RULE19

   // Multiplier and divider iterate on their own; the sequencer
   // only waits for their done pulses and never touches their state
   eau_mul u_mul (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .start(mul_start),
      .mcand(mul_a),
      .mplier(mul_b),
      .done(mul_done),
      .product(mul_prod) // RULE1
   );

   eau_div u_div (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .start(div_start),
      .dividend(div_n),
      .divisor(div_d),
      .done(div_done),
      .ovf(div_ovf),
      .quot(div_q),
      .rem(div_r)
   );

   // Interrupt and transfer request pins pass two flops before use
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_s1 <= 1'b0;
         irq_s2 <= 1'b0;
         npr_s1 <= 1'b0;
         npr_s2 <= 1'b0;
      end else begin
         irq_s1 <= irq_pending;
         irq_s2 <= irq_s1;
         npr_s1 <= nonprocessor_transfer_request;
         npr_s2 <= npr_s1;
      end
   end

   // Next state of the sequencer
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start) begin
               case (op_sel)
                  `EAU_OP_MUL: next_state = ST_MUL;
                  `EAU_OP_DIV: next_state = ST_DIV;
                  default: next_state = ST_SHIFT;
               endcase
            end
         end
         ST_MUL: begin
            if (mul_done) begin
               next_state = ST_IDLE;
            end
         end
         ST_DIV: begin
            if (div_done) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            if (sh_left_cnt == 6'h0) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   // Sequencer, operand capture and write-back to the general registers.
   // No result is kept here; the core owns all architectural state.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         r_num <= 3'h0;
         sh_val <= 32'h0;
         sh_pair <= 1'b0;
         sh_rot <= 1'b0;
         sh_left <= 1'b0;
         sh_left_cnt <= 6'h0;
         step_cnt <= 5'h0;
         sh_v <= 1'b0;
         sh_c <= 1'b0;
         mul_start <= 1'b0;
         div_start <= 1'b0;
         mul_a <= 16'h0;
         mul_b <= 16'h0;
         div_n <= 32'h0;
         div_d <= 16'h0;
         busy <= 1'b0;
         done <= 1'b0;
         wr_en_a <= 1'b0;
         wr_addr_a <= 3'h0;
         wr_data_a <= 16'h0;
         wr_en_b <= 1'b0;
         wr_addr_b <= 3'h0;
         wr_data_b <= 16'h0;
         cc_wr <= 1'b0;
         cc_out <= 4'h0;
         trap <= 1'b0;
         processor_status_word <= 16'h0;
         psw_load <= 1'b0;
         irq_take <= 1'b0;
         bus_grant <= 1'b0;
      end else begin
         state <= next_state;
         mul_start <= 1'b0;
         div_start <= 1'b0;
         done <= 1'b0;
         wr_en_a <= 1'b0;
         wr_en_b <= 1'b0;
         cc_wr <= 1'b0;
         trap <= 1'b0;
         psw_load <= 1'b0;
         // Transfers are granted in any state, so latency is untouched
         bus_grant <= npr_s2; // RULE16
         // Interrupts only taken while no instruction runs
         irq_take <= irq_s2 && (state == ST_IDLE) && !start; // RULE17
         busy <= (next_state != ST_IDLE);
         case (state)
            ST_IDLE: begin
               if (start) begin
                  r_num <= reg_num;
                  case (op_sel)
                     `EAU_OP_MUL: begin
                        mul_a <= src_operand;
                        mul_b <= dst_operand;
                        mul_start <= 1'b1;
                     end
                     `EAU_OP_DIV: begin
                        div_n <= dividend;
                        div_d <= dst_operand;
                        div_start <= 1'b1;
                     end
                     default: begin
                        sh_pair <= (op_sel == `EAU_OP_COMBINED_ARITH_SHIFT_OP) && !reg_num[0];
                        sh_rot <= (op_sel == `EAU_OP_COMBINED_ARITH_SHIFT_OP) && reg_num[0]; // RULE13
                        sh_left <= !cnt6[5]; // RULE10
                        // Rotate keeps count within one word
                        // so counts of 16 and more wrap into 0 to 15
                        sh_left_cnt <= ((op_sel == `EAU_OP_COMBINED_ARITH_SHIFT_OP) && reg_num[0])
                                       ? {2'h0, cnt_mag[3:0]} : cnt_mag;
                        step_cnt <= 5'h0;
                        sh_v <= 1'b0;
                        sh_c <= 1'b0;
                        if ((op_sel == `EAU_OP_COMBINED_ARITH_SHIFT_OP) && !reg_num[0]) begin
                           sh_val <= {src_operand, pair_low}; // RULE12
                        end else if (op_sel == `EAU_OP_COMBINED_ARITH_SHIFT_OP) begin
                           sh_val <= {16'h0, src_operand};
                        end else begin
                           sh_val <= {{16{src_operand[15]}}, src_operand};
                        end
                     end
                  endcase
               end
            end
            ST_MUL: begin
               if (mul_done) begin
                  done <= 1'b1;
                  cc_wr <= 1'b1; // RULE14
                  cc_out <= {mul_prod[31], mul_prod == 32'h0, 1'b0,
                             mul_prod[31:15] != {17{mul_prod[15]}}};
                  if (!r_num[0]) begin
                     wr_en_a <= 1'b1; // RULE2 RULE15
                     wr_addr_a <= r_num;
                     wr_data_a <= mul_prod[31:16];
                     wr_en_b <= 1'b1; // RULE2
                     wr_addr_b <= r_num + 3'h1;
                     wr_data_b <= mul_prod[15:0];
                  end else begin
                     wr_en_a <= 1'b1; // RULE3
                     wr_addr_a <= r_num;
                     wr_data_a <= mul_prod[15:0];
                  end
               end
            end
            ST_DIV: begin
               if (div_done) begin
                  done <= 1'b1;
                  cc_wr <= 1'b1; // RULE14
                  if (div_ovf) begin
                     // Abort: no register write, trap with new status
                     cc_out <= {1'b0, 1'b0, 1'b1, div_d == 16'h0}; // RULE6 RULE8
                     trap <= 1'b1; // RULE7
                     psw_load <= 1'b1; // RULE7
                     processor_status_word <= expansion_status_word; // RULE7
                  end else begin
                     cc_out <= {div_q[15], div_q == 16'h0, 2'b00};
                     wr_en_a <= 1'b1; // RULE4 RULE15
                     wr_addr_a <= r_num;
                     wr_data_a <= div_q;
                     wr_en_b <= 1'b1; // RULE4
                     wr_addr_b <= r_num | 3'h1;
                     wr_data_b <= div_r; // RULE5
                  end
               end
            end
            default: begin
               if (sh_left_cnt != 6'h0) begin
                  // Each position costs its own fixed time
                  if (step_cnt == STEP_CYC - 5'h1) begin // RULE18
                     step_cnt <= 5'h0;
                     sh_val <= sh_next;
                     sh_left_cnt <= sh_left_cnt - 6'h1;
                     sh_c <= sh_left ? (sh_pair ? sh_val[31] : sh_val[15]) : sh_val[0];
                     if (sh_left && !sh_rot &&
                         ((sh_pair ? sh_val[31] ^ sh_val[30] : sh_val[15] ^ sh_val[14]))) begin
                        sh_v <= 1'b1;
                     end
                  end else begin
                     step_cnt <= step_cnt + 5'h1;
                  end
               end else begin
                  // Zero count falls through with value unchanged
                  done <= 1'b1; // RULE11
                  cc_wr <= 1'b1; // RULE14
                  wr_en_a <= 1'b1; // RULE15
                  wr_addr_a <= r_num;
                  if (sh_pair) begin
                     wr_data_a <= sh_val[31:16]; // RULE12
                     wr_en_b <= 1'b1;
                     wr_addr_b <= r_num + 3'h1;
                     wr_data_b <= sh_val[15:0];
                     cc_out <= {sh_val[31], sh_val == 32'h0, sh_v, sh_c};
                  end else begin
                     wr_data_a <= sh_val[15:0];
                     cc_out <= {sh_val[15], sh_val[15:0] == 16'h0, sh_v, sh_c};
                  end
               end
            end
         endcase
      end
   end
endmodule

// File: sim/eau_props.sv
// Checker for eau_top: latency, write pairing, trap and pin handshakes.
// Assumes the core holds expansion_status_word steady around a trap.
`timescale 1ns/1ps
`include "eau_defines.vh"
module eau_props (
   input wire sys_clk,
   input wire rst_n,
   input wire start,
   input wire [1:0] op_sel,
   input wire [2:0] reg_num,
   input wire [15:0] src_operand,
   input wire [15:0] dst_operand,
   input wire [15:0] expansion_status_word,
   input wire nonprocessor_transfer_request,
   input wire busy,
   input wire done,
   input wire wr_en_a,
   input wire [2:0] wr_addr_a,
   input wire [15:0] wr_data_a,
   input wire wr_en_b,
   input wire [2:0] wr_addr_b,
   input wire [3:0] cc_out,
   input wire trap,
   input wire [15:0] processor_status_word,
   input wire psw_load,
   input wire irq_take,
   input wire bus_grant
);
   reg [1:0] op;
   reg [2:0] rn;
   reg rot;
   reg zdiv;
   reg [9:0] cyc;
   reg [9:0] want;
   wire acc = start && !busy && !done;
   wire [5:0] n6 = dst_operand[5:0];
   wire [5:0] mag = n6[5] ? 6'h00 - n6 : n6;
   wire [9:0] lat = (op_sel == `EAU_OP_MUL) ? 10'h012 :
      (op_sel == `EAU_OP_DIV) ? ((dst_operand == 16'h0000) ? 10'h002 : 10'h023) :
      10'h001 + 10'h00F * {4'h0, mag};
   // Remember the accepted request; rotate latency is left out as its count is folded
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         op <= 2'h0;
         rn <= 3'h0;
         rot <= 1'b0;
         zdiv <= 1'b0;
         cyc <= 10'h000;
         want <= 10'h000;
      end else if (acc) begin
         op <= op_sel;
         rn <= reg_num;
         rot <= op_sel == `EAU_OP_COMBINED_ARITH_SHIFT_OP && reg_num[0];
         zdiv <= dst_operand == 16'h0000;
         cyc <= 10'h000;
         want <= lat;
      end else begin
         cyc <= cyc + 10'h001;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   done_latency_a:
      assert property (done && !rot && !(trap && !zdiv) |-> cyc == want) else $error("latency");
   zero_div_a:
      assert property (acc && op_sel == `EAU_OP_DIV && dst_operand == 16'h0000 |->
         ##3 done && trap && cc_out[`EAU_CC_V] && cc_out[`EAU_CC_C]) else $error("zero div");
   trap_abort_a:
      assert property (trap |-> done && psw_load && !wr_en_a && !wr_en_b && cc_out[`EAU_CC_V])
         else $error("trap abort");
   psw_load_a:
      assert property (trap |=> processor_status_word == expansion_status_word)
         else $error("status load");
   odd_mul_a:
      assert property (done && op == `EAU_OP_MUL && rn[0] |-> wr_en_a && !wr_en_b &&
         wr_addr_a == rn) else $error("odd multiply");
   pair_write_a:
      assert property (done && !trap && !rn[0] && op != `EAU_OP_ASH |-> wr_en_b &&
         wr_addr_a == rn && wr_addr_b == (rn | 3'h1)) else $error("pair write");
   zero_count_a:
      assert property (acc && op_sel[1] && n6 == 6'h00 |->
         ##2 done && wr_data_a == $past(src_operand, 2)) else $error("zero count");
   bus_grant_a:
      assert property (nonprocessor_transfer_request [*4] |-> bus_grant) else $error("grant");
   irq_wait_a:
      assert property (irq_take |-> !busy) else $error("irq in op");
endmodule
bind eau_top eau_props u_eau_props (.sys_clk, .rst_n, .start, .op_sel, .reg_num,
   .src_operand, .dst_operand, .expansion_status_word, .nonprocessor_transfer_request,
   .busy, .done, .wr_en_a, .wr_addr_a, .wr_data_a, .wr_en_b, .wr_addr_b, .cc_out, .trap,
   .processor_status_word, .psw_load, .irq_take, .bus_grant);

// File: sim/eau_host_model.sv
// Host side of the unit: general registers and the status word.
// Assumes results are presented for one cycle with their write enables.
`timescale 1ns/1ps
module eau_host_model (
   input wire sys_clk,
   input wire rst_n,
   input wire wr_en_a,
   input wire [2:0] wr_addr_a,
   input wire [15:0] wr_data_a,
   input wire wr_en_b,
   input wire [2:0] wr_addr_b,
   input wire [15:0] wr_data_b,
   input wire psw_load,
   input wire [15:0] processor_status_word
);
   reg [15:0] gpr [0:7];
   reg [15:0] psw;
   reg ld_d;
   // Results land only here; status taken a cycle late so it has settled
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         psw <= 16'h0000;
         ld_d <= 1'b0;
      end else begin
         if (wr_en_a) gpr[wr_addr_a] <= wr_data_a;
         if (wr_en_b) gpr[wr_addr_b] <= wr_data_b;
         ld_d <= psw_load;
         if (ld_d) psw <= processor_status_word;
      end
   end
endmodule

// File: sim/eau_top_bench.sv
// Self-checking bench for eau_top with the host register model.
// Assumes a 50 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
`include "eau_defines.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module eau_top_bench;
   typedef struct packed {
      logic [1:0] op;
      logic [2:0] rn;
      logic [15:0] src;
      logic [15:0] low;
      logic [15:0] dst;
      logic [15:0] ea;
      logic [15:0] eb;
      logic [3:0] cc;
      logic [9:0] cyc;
   } eau_case_t;
   reg sys_clk = 1'b0;
   reg rst_n = 1'b0;
   reg start = 1'b0;
   reg [1:0] op_sel = 2'h0;
   reg [2:0] reg_num = 3'h0;
   reg [15:0] src_operand = 16'h0000;
   reg [15:0] pair_low = 16'h0000;
   reg [15:0] dst_operand = 16'h0000;
   reg [15:0] esw = 16'h0000;
   reg dma_req = 1'b0;
   reg irq = 1'b0;
   wire busy, done, wr_en_a, wr_en_b, cc_wr, trap, psw_load, irq_take, bus_grant;
   wire [2:0] wr_addr_a, wr_addr_b;
   wire [15:0] wr_data_a, wr_data_b, psw;
   wire [3:0] cc_out;
   int error_cnt = 0;
   int checked = 0;
   int now = 0;
   int t0 = 0;
   int lat = 0;
   eau_case_t r;
   // Ordinary cases; the last three overflow
   eau_case_t rows [0:14] = '{
   '{2'h0, 3'h2, 16'h0003, 16'h0000, 16'hFFFB, 16'hFFFF, 16'hFFF1, 4'h8, 10'h012},
   '{2'h0, 3'h3, 16'h0100, 16'h0000, 16'h0100, 16'h0000, 16'h0000, 4'h1, 10'h012},
   '{2'h0, 3'h0, 16'h8000, 16'h0000, 16'h8000, 16'h4000, 16'h0000, 4'h1, 10'h012},
   '{2'h1, 3'h4, 16'hFFFF, 16'hFFF9, 16'h0002, 16'hFFFD, 16'hFFFF, 4'h8, 10'h023},
   '{2'h2, 3'h1, 16'h0001, 16'h0000, 16'h000F, 16'h8000, 16'h0000, 4'hA, 10'h0E2},
   '{2'h2, 3'h2, 16'h8000, 16'h0000, 16'h0030, 16'hFFFF, 16'h0000, 4'h9, 10'h0F1},
   '{2'h2, 3'h5, 16'h1234, 16'h0000, 16'h0040, 16'h1234, 16'h0000, 4'h0, 10'h001},
   '{2'h3, 3'h2, 16'h0000, 16'h8001, 16'h0001, 16'h0001, 16'h0002, 4'h0, 10'h010},
   '{2'h3, 3'h0, 16'h8000, 16'h0000, 16'h0020, 16'hFFFF, 16'hFFFF, 4'h9, 10'h1E1},
   '{2'h3, 3'h4, 16'h0000, 16'h0001, 16'h001F, 16'h8000, 16'h0000, 4'hA, 10'h1D2},
   '{2'h3, 3'h3, 16'h8001, 16'h0000, 16'h0004, 16'h0018, 16'h0000, 4'h0, 10'h03D},
   '{2'h3, 3'h5, 16'h8001, 16'h0000, 16'h003E, 16'h6000, 16'h0000, 4'h0, 10'h01F},
   '{2'h1, 3'h2, 16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 4'h2, 10'h000},
   '{2'h1, 3'h2, 16'hFFFF, 16'h8000, 16'hFFFF, 16'h0000, 16'h0000, 4'h2, 10'h000},
   '{2'h1, 3'h2, 16'h0000, 16'h0005, 16'h0000, 16'h0000, 16'h0000, 4'h3, 10'h002}};
   eau_top u_eau_top (.sys_clk(sys_clk), .rst_n(rst_n), .start(start), .op_sel(op_sel),
      .reg_num(reg_num), .src_operand(src_operand), .pair_low(pair_low),
      .dst_operand(dst_operand), .expansion_status_word(esw),
      .nonprocessor_transfer_request(dma_req), .irq_pending(irq), .busy(busy), .done(done),
      .wr_en_a(wr_en_a), .wr_addr_a(wr_addr_a), .wr_data_a(wr_data_a), .wr_en_b(wr_en_b),
      .wr_addr_b(wr_addr_b), .wr_data_b(wr_data_b), .cc_wr(cc_wr), .cc_out(cc_out),
      .trap(trap), .processor_status_word(psw), .psw_load(psw_load), .irq_take(irq_take),
      .bus_grant(bus_grant));
   eau_host_model u_eau_host_model (.sys_clk(sys_clk), .rst_n(rst_n), .wr_en_a(wr_en_a),
      .wr_addr_a(wr_addr_a), .wr_data_a(wr_data_a), .wr_en_b(wr_en_b), .wr_addr_b(wr_addr_b),
      .wr_data_b(wr_data_b), .psw_load(psw_load), .processor_status_word(psw));
   // Clock and a free edge count for latency
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) now <= now + 1;
   task conclude;
      $display("checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // One-cycle start pulse; operands stay put until the next request
   task kick(input eau_case_t c);
      @(negedge sys_clk);
      start = 1'b1;
      op_sel = c.op;
      reg_num = c.rn;
      src_operand = c.src;
      pair_low = c.low;
      dst_operand = c.dst;
      t0 = now;
      @(negedge sys_clk);
      start = 1'b0;
   endtask
   // Bounded wait; lat is edges from the start edge to done
   task finish_op;
      for (int k = 0; k < 600 && done !== 1'b1; k++) begin
         @(posedge sys_clk);
         #1;
      end
      lat = now - t0 - 1;
   endtask
   task do_row(input int i);
      logic [3:0] m;
      logic pair;
      r = rows[i];
      m = (r.op == `EAU_OP_COMBINED_ARITH_SHIFT_OP && r.rn[0]) ? 4'hC : (r.op[1] && r.dst[5:0] == 6'h00) ? 4'hE : 4'hF;
      pair = !r.rn[0] && r.op != `EAU_OP_ASH;
      kick(r);
      finish_op;
      `CHK("latency", r.cyc, lat)
      `CHK("cc", r.cc & m, cc_out & m)
      `CHK("second write", pair, wr_en_b)
      `CHK("cc write", 1'b1, cc_wr)
      @(posedge sys_clk);
      #1;
      `CHK("reg R", r.ea, u_eau_host_model.gpr[r.rn])
      if (pair) `CHK("reg R+1", r.eb, u_eau_host_model.gpr[r.rn + 3'h1])
      $display("case %0d done", i);
   endtask
   // Watchdog: the run needs about 2000 cycles, give it 20000
   initial begin
      #400000;
      error_cnt++;
      conclude;
   end
   initial begin
      repeat (3) @(negedge sys_clk);
      `CHK("reset busy", 1'b0, busy)
      `CHK("reset cc", 4'h0, cc_out)
      $display("reset test done");
      repeat (2) @(negedge sys_clk);
      rst_n = 1'b1;
      for (int i = 0; i < 12; i++) do_row(i);
      // Overflow and zero divisor abort and trap
      for (int i = 12; i < 15; i++) begin
         r = rows[i];
         @(negedge sys_clk);
         esw = 16'hA5A0 + 16'(i);
         kick(r);
         finish_op;
         `CHK("trap", 1'b1, trap)
         `CHK("no write", 1'b0, wr_en_a)
         `CHK("cc vc", r.cc, cc_out & 4'h3)
         if (r.cyc != 10'h000) `CHK("latency", r.cyc, lat)
         repeat (2) @(posedge sys_clk);
         #1;
         `CHK("status", esw, u_eau_host_model.psw)
         $display("overflow %0d done", i);
      end
      // Refused start, transfer grant and held interrupt during a long shift
      r = rows[4];
      kick(r);
      repeat (3) @(negedge sys_clk);
      start = 1'b1;
      op_sel = `EAU_OP_MUL;
      @(negedge sys_clk);
      start = 1'b0;
      dma_req = 1'b1;
      irq = 1'b1;
      repeat (5) @(negedge sys_clk);
      `CHK("grant", 1'b1, bus_grant)
      `CHK("irq held", 1'b0, irq_take)
      finish_op;
      `CHK("refused latency", r.cyc, lat)
      `CHK("refused result", r.ea, wr_data_a)
      repeat (4) @(negedge sys_clk);
      `CHK("irq taken", 1'b1, irq_take)
      dma_req = 1'b0;
      irq = 1'b0;
      $display("busy test done");
      // Reset in mid-run, then a quick request
      kick(rows[8]);
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b0;
      @(negedge sys_clk);
      `CHK("mid reset busy", 1'b0, busy)
      rst_n = 1'b1;
      do_row(6);
      conclude;
   end
endmodule
